// ---- sos_pkg.sv ----
package sos_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFF_SEL_LO   = 8'h00;
  localparam logic [7:0] OFF_SEL_HI   = 8'h04;
  localparam logic [7:0] OFF_TRQ_CMP  = 8'h08;
  localparam logic [7:0] OFF_TRQ_WIN  = 8'h0c;
  localparam logic [7:0] OFF_TRQ_TC   = 8'h10;
  localparam logic [7:0] OFF_SPD_CMP  = 8'h14;
  localparam logic [7:0] OFF_SPD_WIN  = 8'h18;
  localparam logic [7:0] OFF_SPD_DLY  = 8'h1c;
  localparam logic [7:0] OFF_SPD_THR2 = 8'h20;
  localparam logic [7:0] OFF_TGT_NEG  = 8'h24;
  localparam logic [7:0] OFF_TGT_POS  = 8'h28;
  localparam logic [7:0] OFF_TGT_DLY  = 8'h2c;
  localparam logic [7:0] OFF_FE_NEG   = 8'h30;
  localparam logic [7:0] OFF_FE_POS   = 8'h34;
  localparam logic [7:0] OFF_FE_DLY   = 8'h38;
  localparam logic [7:0] OFF_TRIG_CFG = 8'h3c;
  localparam logic [7:0] OFF_TRIG_MAP = 8'h40;
  localparam logic [7:0] OFF_PT_LEFT  = 8'h44;
  localparam logic [7:0] OFF_PT_RIGHT = 8'h54;
  localparam logic [7:0] OFF_RT_LEFT  = 8'h64;
  localparam logic [7:0] OFF_RT_RIGHT = 8'h74;
  localparam logic [7:0] OFF_STATUS   = 8'h84;
  localparam logic [7:0] OFF_FILT     = 8'h88;
  localparam logic [7:0] GRP_SPAN     = 8'h10;

  // ==========================================
  // sizes
  localparam int N_DOUT   = 8;
  localparam int N_TRIG   = 4;
  localparam int SEL_W    = 5;
  localparam int DLY_W    = 16;
  localparam int FILT_FRAC = 16;

  // ==========================================
  // output function codes
  localparam logic [4:0] FN_OFF        = 5'h00;
  localparam logic [4:0] FN_ON         = 5'h01;
  localparam logic [4:0] FN_OVERLOAD   = 5'h02;
  localparam logic [4:0] FN_SPEED      = 5'h03;
  localparam logic [4:0] FN_TARGET     = 5'h04;
  localparam logic [4:0] FN_REMAINING  = 5'h05;
  localparam logic [4:0] FN_HOME_ACT   = 5'h06;
  localparam logic [4:0] FN_HOME_VALID = 5'h07;
  localparam logic [4:0] FN_UNDERVOLT  = 5'h08;
  localparam logic [4:0] FN_FOLLOW     = 5'h09;
  localparam logic [4:0] FN_STAGE      = 5'h0a;
  localparam logic [4:0] FN_BRAKE      = 5'h0b;
  localparam logic [4:0] FN_LINEAR     = 5'h0c;
  localparam logic [4:0] FN_TRIG1      = 5'h0d;
  localparam logic [4:0] FN_SETPT_LOCK = 5'h11;
  localparam logic [4:0] FN_TORQUE     = 5'h12;
  localparam logic [4:0] FN_SET_ACTIVE = 5'h13;
  localparam logic [4:0] FN_READY      = 5'h14;
  localparam logic [4:0] FN_ERROR      = 5'h15;

  // ==========================================
  // timing: delays and filter run on a 1 us tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
endpackage

// ---- sos_qual.sv ----
`timescale 1ns/10ps
// ==========================================
// response delay qualifier
module sos_qual (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  input  wire logic                      i_tick,
  input  wire logic                      i_cond,
  input  wire logic [sos_pkg::DLY_W-1:0] i_dly,
  output logic                           o_q
);
  typedef struct packed {
    logic [sos_pkg::DLY_W-1:0] cnt;
    logic                      q;
  } sos_qual_state_t;

  sos_qual_state_t s_q;
  sos_qual_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (!i_cond) begin
      s_d.cnt = '0;
      s_d.q   = 1'b0;
    end else if (s_q.cnt >= i_dly) begin
      s_d.q = 1'b1;
    end else if (i_tick) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_q = s_q.q;
endmodule

// ---- sos_top.sv ----
`timescale 1ns/10ps
module sos_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic [15:0] i_current,
  input  wire logic [31:0] i_speed,
  input  wire logic [31:0] i_pos_act,
  input  wire logic [31:0] i_pos_target,
  input  wire logic [31:0] i_pos_set,
  input  wire logic [15:0] i_rotor_angle,
  input  wire logic        i_overload,
  input  wire logic        i_remaining,
  input  wire logic        i_home_act,
  input  wire logic        i_home_valid,
  input  wire logic        i_undervolt,
  input  wire logic        i_stage_en,
  input  wire logic        i_brake_rel,
  input  wire logic        i_linear_id,
  input  wire logic        i_setpt_lock,
  input  wire logic        i_set_active,
  input  wire logic        i_ready,
  input  wire logic        i_error,
  output logic      [7:0]  o_dout,
  output logic      [7:0]  o_trig_src,
  output logic      [3:0]  o_trig_out,
  output logic             o_spd_thr2
);
  // ==========================================
  // state
  typedef struct packed {
    logic [7:0][4:0]  sel;
    logic [15:0]      trq_cmp;
    logic [15:0]      trq_win;
    logic [3:0]       trq_tc;
    logic [31:0]      spd_cmp;
    logic [31:0]      spd_win;
    logic [15:0]      spd_dly;
    logic [31:0]      spd_thr2;
    logic [31:0]      tgt_neg;
    logic [31:0]      tgt_pos;
    logic [15:0]      tgt_dly;
    logic [31:0]      fe_neg;
    logic [31:0]      fe_pos;
    logic [15:0]      fe_dly;
    logic [3:0]       en_pos;
    logic [3:0]       en_rot;
    logic [3:0]       inv_pos;
    logic [3:0]       inv_rot;
    logic [3:0][7:0]  map;
    logic [3:0][31:0] pt_l;
    logic [3:0][31:0] pt_r;
    logic [3:0][15:0] rt_l;
    logic [3:0][15:0] rt_r;
    logic [31:0]      filt;
    logic [6:0]       div;
    logic             tick;
    logic             pend;
    logic             pwrite;
    logic [7:0]       paddr;
    logic             hready;
    logic [31:0]      hrdata;
    logic [7:0]       dout;
    logic [7:0]       tsrc;
    logic [3:0]       tout;
    logic             thr2;
    logic             refused;
  } sos_top_state_t;

  sos_top_state_t s_q;
  sos_top_state_t s_d;

  logic q_speed;
  logic q_target;
  logic q_follow;
  logic w_trq;
  logic w_spd;
  logic w_tgt;
  logic w_fe;

  // ==========================================
  // helpers
  function automatic logic in_win(input logic [31:0] v, input logic [31:0] r,
                                  input logic [31:0] n, input logic [31:0] p);
    logic signed [33:0] vv;
    logic signed [33:0] lo;
    logic signed [33:0] hi;
    vv = $signed({{2{v[31]}}, v});
    lo = $signed({{2{r[31]}}, r}) - $signed({2'b00, n});
    hi = $signed({{2{r[31]}}, r}) + $signed({2'b00, p});
    return (vv >= lo) && (vv <= hi);
  endfunction

  function automatic logic trig_lvl(input logic [31:0] v, input logic [31:0] l,
                                    input logic [31:0] r, input logic inv);
    return inv ^ (($signed(v) >= $signed(l)) && ($signed(v) <= $signed(r)));
  endfunction

  function automatic logic [31:0] sx16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  // slot k of a four-word edge group; edge 1 sits at the group base
  function automatic logic in_grp(input logic [7:0] a, input logic [7:0] base, input int k);
    return a == 8'(base + (k * (sos_pkg::GRP_SPAN / sos_pkg::N_TRIG)));
  endfunction

  // ==========================================
  // window comparators and qualifiers
  assign w_trq = in_win(sx16(s_q.filt[31:16]), sx16(s_q.trq_cmp),
                        {16'h0000, s_q.trq_win}, {16'h0000, s_q.trq_win});
  assign w_spd = in_win(i_speed, s_q.spd_cmp, s_q.spd_win, s_q.spd_win);
  assign w_tgt = in_win(i_pos_act, i_pos_target, s_q.tgt_neg, s_q.tgt_pos);
  assign w_fe  = !in_win(i_pos_act, i_pos_set, s_q.fe_neg, s_q.fe_pos);

  sos_qual u_q_speed (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_tick  (s_q.tick),
    .i_cond  (w_spd),
    .i_dly   (s_q.spd_dly),
    .o_q     (q_speed)
  );

  // the flag falls only when the position leaves the current target window
  sos_qual u_q_target (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_tick  (s_q.tick),
    .i_cond  (w_tgt),
    .i_dly   (s_q.tgt_dly),
    .o_q     (q_target)
  );

  sos_qual u_q_follow (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_tick  (s_q.tick),
    .i_cond  (w_fe),
    .i_dly   (s_q.fe_dly),
    .o_q     (q_follow)
  );

  // ==========================================
  // next state
  always_comb begin
    logic [7:0]        src;
    logic [31:0]       fn;
    logic signed [31:0] err;
    logic [7:0]        a;
    logic [7:0]        nb;
    logic [3:0]        np;
    logic [3:0]        nr;
    logic [31:0]       rd;
    src = '0;
    fn  = '0;
    err = '0;
    a   = '0;
    nb  = '0;
    np  = '0;
    nr  = '0;
    rd  = '0;
    s_d = s_q;

    // tick divider
    s_d.tick = 1'b0;
    if (s_q.div == sos_pkg::TICK_LAST) begin
      s_d.div  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 1'b1;
    end

    // first order lag on the actual current, tau = 2^tc ticks
    if (s_q.tick) begin
      err = $signed({i_current, 16'h0000}) - $signed(s_q.filt);
      s_d.filt = 32'($signed(s_q.filt) + (err >>> s_q.trq_tc));
    end

    // trigger sources, inactive ones forced low
    for (int k = 0; k < sos_pkg::N_TRIG; k++) begin
      src[k] = s_q.en_pos[k] & trig_lvl(i_pos_act, s_q.pt_l[k], s_q.pt_r[k], s_q.inv_pos[k]);
      src[k+4] = s_q.en_rot[k] & trig_lvl(sx16(i_rotor_angle), sx16(s_q.rt_l[k]),
                                          sx16(s_q.rt_r[k]), s_q.inv_rot[k]);
    end
    s_d.tsrc = src;
    for (int k = 0; k < sos_pkg::N_TRIG; k++) begin
      s_d.tout[k] = |(s_q.map[k] & src);
    end

    // function sources
    fn[sos_pkg::FN_OFF]        = 1'b0;
    fn[sos_pkg::FN_ON]         = 1'b1;
    fn[sos_pkg::FN_OVERLOAD]   = i_overload;
    fn[sos_pkg::FN_SPEED]      = q_speed;
    fn[sos_pkg::FN_TARGET]     = q_target;
    fn[sos_pkg::FN_REMAINING]  = i_remaining;
    fn[sos_pkg::FN_HOME_ACT]   = i_home_act;
    fn[sos_pkg::FN_HOME_VALID] = i_home_valid;
    fn[sos_pkg::FN_UNDERVOLT]  = i_undervolt;
    fn[sos_pkg::FN_FOLLOW]     = q_follow;
    fn[sos_pkg::FN_STAGE]      = i_stage_en;
    fn[sos_pkg::FN_BRAKE]      = i_brake_rel;
    fn[sos_pkg::FN_LINEAR]     = i_linear_id;
    for (int k = 0; k < sos_pkg::N_TRIG; k++) begin
      fn[5'(sos_pkg::FN_TRIG1 + k)] = s_q.tout[k];
    end
    fn[sos_pkg::FN_SETPT_LOCK] = i_setpt_lock;
    fn[sos_pkg::FN_TORQUE]     = w_trq;
    fn[sos_pkg::FN_SET_ACTIVE] = i_set_active;
    fn[sos_pkg::FN_READY]      = i_ready;
    fn[sos_pkg::FN_ERROR]      = i_error;
    for (int i = 0; i < sos_pkg::N_DOUT; i++) begin
      s_d.dout[i] = fn[s_q.sel[i]];
    end

    // second threshold goes to the status word and to o_spd_thr2, not to the output selectors
    s_d.thr2 = $signed(i_speed) >= $signed(s_q.spd_thr2);

    // ==========================================
    // bus: one wait state per transfer
    if (s_q.pend) begin
      a = s_q.paddr;
      s_d.pend   = 1'b0;
      s_d.hready = 1'b1;
      if (s_q.pwrite) begin
        unique case (a)
          sos_pkg::OFF_SEL_LO: begin
            for (int i = 0; i < 4; i++) s_d.sel[i] = i_hwdata[8*i +: sos_pkg::SEL_W];
          end
          sos_pkg::OFF_SEL_HI: begin
            for (int i = 0; i < 4; i++) s_d.sel[i+4] = i_hwdata[8*i +: sos_pkg::SEL_W];
          end
          sos_pkg::OFF_TRQ_CMP:  s_d.trq_cmp  = i_hwdata[15:0];
          sos_pkg::OFF_TRQ_WIN:  s_d.trq_win  = i_hwdata[15:0];
          sos_pkg::OFF_TRQ_TC:   s_d.trq_tc   = i_hwdata[3:0];
          sos_pkg::OFF_SPD_CMP:  s_d.spd_cmp  = i_hwdata;
          sos_pkg::OFF_SPD_WIN:  s_d.spd_win  = i_hwdata;
          sos_pkg::OFF_SPD_DLY:  s_d.spd_dly  = i_hwdata[15:0];
          sos_pkg::OFF_SPD_THR2: s_d.spd_thr2 = i_hwdata;
          sos_pkg::OFF_TGT_NEG:  s_d.tgt_neg  = i_hwdata;
          sos_pkg::OFF_TGT_POS:  s_d.tgt_pos  = i_hwdata;
          sos_pkg::OFF_TGT_DLY:  s_d.tgt_dly  = i_hwdata[15:0];
          sos_pkg::OFF_FE_NEG:   s_d.fe_neg   = i_hwdata;
          sos_pkg::OFF_FE_POS:   s_d.fe_pos   = i_hwdata;
          sos_pkg::OFF_FE_DLY:   s_d.fe_dly   = i_hwdata[15:0];
          sos_pkg::OFF_TRIG_CFG: begin
            s_d.en_pos  = i_hwdata[3:0];
            s_d.en_rot  = i_hwdata[7:4];
            s_d.inv_pos = i_hwdata[11:8];
            s_d.inv_rot = i_hwdata[15:12];
            for (int k = 0; k < sos_pkg::N_TRIG; k++) begin
              s_d.map[k] = s_q.map[k] & {i_hwdata[7:4], i_hwdata[3:0]};
            end
          end
          sos_pkg::OFF_TRIG_MAP: begin
            s_d.refused = 1'b0;
            for (int k = 0; k < sos_pkg::N_TRIG; k++) begin
              nb = i_hwdata[8*k +: 8];
              np = nb[3:0] & s_q.en_pos;
              nr = nb[7:4] & s_q.en_rot;
              if ((nr != '0) && ((np != '0) || (s_q.map[k][3:0] != '0))) begin
                s_d.refused = 1'b1;
              end else begin
                s_d.map[k] = {nr, np};
              end
            end
          end
          default: begin
            for (int k = 0; k < sos_pkg::N_TRIG; k++) begin
              if (in_grp(a, sos_pkg::OFF_PT_LEFT, k)) s_d.pt_l[k] = i_hwdata;
              if (in_grp(a, sos_pkg::OFF_PT_RIGHT, k)) s_d.pt_r[k] = i_hwdata;
              if (in_grp(a, sos_pkg::OFF_RT_LEFT, k)) s_d.rt_l[k] = i_hwdata[15:0];
              if (in_grp(a, sos_pkg::OFF_RT_RIGHT, k)) s_d.rt_r[k] = i_hwdata[15:0];
            end
          end
        endcase
      end else begin
        unique case (a)
          sos_pkg::OFF_SEL_LO: begin
            for (int i = 0; i < 4; i++) rd[8*i +: sos_pkg::SEL_W] = s_q.sel[i];
          end
          sos_pkg::OFF_SEL_HI: begin
            for (int i = 0; i < 4; i++) rd[8*i +: sos_pkg::SEL_W] = s_q.sel[i+4];
          end
          sos_pkg::OFF_TRQ_CMP:  rd = {16'h0000, s_q.trq_cmp};
          sos_pkg::OFF_TRQ_WIN:  rd = {16'h0000, s_q.trq_win};
          sos_pkg::OFF_TRQ_TC:   rd = {28'h0000000, s_q.trq_tc};
          sos_pkg::OFF_SPD_CMP:  rd = s_q.spd_cmp;
          sos_pkg::OFF_SPD_WIN:  rd = s_q.spd_win;
          sos_pkg::OFF_SPD_DLY:  rd = {16'h0000, s_q.spd_dly};
          sos_pkg::OFF_SPD_THR2: rd = s_q.spd_thr2;
          sos_pkg::OFF_TGT_NEG:  rd = s_q.tgt_neg;
          sos_pkg::OFF_TGT_POS:  rd = s_q.tgt_pos;
          sos_pkg::OFF_TGT_DLY:  rd = {16'h0000, s_q.tgt_dly};
          sos_pkg::OFF_FE_NEG:   rd = s_q.fe_neg;
          sos_pkg::OFF_FE_POS:   rd = s_q.fe_pos;
          sos_pkg::OFF_FE_DLY:   rd = {16'h0000, s_q.fe_dly};
          sos_pkg::OFF_TRIG_CFG: rd = {16'h0000, s_q.inv_rot, s_q.inv_pos, s_q.en_rot, s_q.en_pos};
          sos_pkg::OFF_TRIG_MAP: rd = s_q.map;
          sos_pkg::OFF_STATUS:   rd = {6'h00, s_q.refused, s_q.thr2, s_q.dout, q_follow, q_target,
                                       q_speed, w_trq, s_q.tout, s_q.tsrc};
          sos_pkg::OFF_FILT:     rd = {16'h0000, s_q.filt[31:16]};
          default: begin
            for (int k = 0; k < sos_pkg::N_TRIG; k++) begin
              if (in_grp(a, sos_pkg::OFF_PT_LEFT, k)) rd = s_q.pt_l[k];
              if (in_grp(a, sos_pkg::OFF_PT_RIGHT, k)) rd = s_q.pt_r[k];
              if (in_grp(a, sos_pkg::OFF_RT_LEFT, k)) rd = sx16(s_q.rt_l[k]);
              if (in_grp(a, sos_pkg::OFF_RT_RIGHT, k)) rd = sx16(s_q.rt_r[k]);
            end
          end
        endcase
        s_d.hrdata = rd;
      end
    end else if (i_hsel && (i_htrans == sos_pkg::HTRANS_NONSEQ_BIT) && i_hready) begin
      s_d.pend   = 1'b1;
      s_d.pwrite = i_hwrite;
      s_d.paddr  = (i_haddr[31:8] == '0) ? i_haddr[7:0] : 8'hfc;
      s_d.hready = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q        <= '0;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs
  assign o_hrdata    = s_q.hrdata;
  assign o_hreadyout = s_q.hready;
  assign o_hresp     = 1'b0;
  assign o_dout      = s_q.dout;
  assign o_trig_src  = s_q.tsrc;
  assign o_trig_out  = s_q.tout;
  assign o_spd_thr2  = s_q.thr2;
endmodule

// ---- sos_ctrl_model.sv ----
`timescale 1ns/10ps
// ==========================================
// machine controller polling the drive outputs
module sos_ctrl_model #(
  parameter int SAMPLE_DIV = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [7:0] i_dout,
  output logic      [7:0] o_seen
);
  int cnt;

  // slow poll: only every SAMPLE_DIV cycles
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt    <= 0;
      o_seen <= 8'h00;
    end else if (cnt == SAMPLE_DIV - 1) begin
      cnt    <= 0;
      o_seen <= i_dout;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ---- sos_chk.sv ----
`timescale 1ns/10ps
module sos_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [7:0]  o_dout,
  input wire logic [7:0]  o_trig_src,
  input wire logic [3:0]  o_trig_out
);
  logic take;

  assign take = i_hsel && (i_htrans == 2'h2) && i_hready && o_hreadyout;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // ==========================================
  // bus steps
  sequence s_busy_done;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  sequence s_status_rd;
    take && !i_hwrite && (i_haddr == {24'h0, sos_pkg::OFF_STATUS});
  endsequence

  a_take_answer: assert property (take |=> s_busy_done) else $error("bus answer shape");
  a_ready_cause: assert property ($fell(o_hreadyout) |-> $past(take)) else $error("stall without request");
  a_ready_idle: assert property (!take |=> o_hreadyout) else $error("ready low when idle");
  a_resp_okay: assert property (o_hresp == 1'b0) else $error("response not okay");
  a_rdata_hold: assert property (!take && o_hreadyout |=> $stable(o_hrdata)) else $error("read data moved");
  a_unmapped_zero: assert property (take && !i_hwrite && (i_haddr >= 32'h100) |=> ##1 (o_hrdata == 32'h0))
    else $error("unmapped read not zero");
  a_trig_cause: assert property ((o_trig_out != 4'h0) |-> (o_trig_src != 8'h00))
    else $error("trigger out without source");
  a_status_trig: assert property (s_status_rd |=> ##1 (o_hrdata[11:0] == {$past(o_trig_out), $past(o_trig_src)}))
    else $error("status trigger bits wrong");
  a_status_dout: assert property (s_status_rd |=> ##1 (o_hrdata[23:16] == $past(o_dout)))
    else $error("status output bits wrong");
endmodule

bind sos_top sos_chk u_sos_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_dout(o_dout), .o_trig_src(o_trig_src),
  .o_trig_out(o_trig_out));

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, speed = 32'h0, pos_act = 32'h0, pos_tgt = 32'h0, pos_set = 32'h0;
  logic [15:0] current = 16'h0, angle = 16'h0;
  logic [11:0] misc = 12'h0;
  logic [31:0] hrdata, r;
  logic        hready, hresp, thr2;
  logic [7:0]  dout, tsrc, seen;
  logic [3:0]  tout;
  int          failures = 0, samples_checked = 0, cycles = 0;

  sos_top u_sos_top (.i_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_current(current), .i_speed(speed), .i_pos_act(pos_act),
    .i_pos_target(pos_tgt), .i_pos_set(pos_set), .i_rotor_angle(angle), .i_overload(misc[0]),
    .i_remaining(misc[1]), .i_home_act(misc[2]), .i_home_valid(misc[3]), .i_undervolt(misc[4]),
    .i_stage_en(misc[5]), .i_brake_rel(misc[6]), .i_linear_id(misc[7]), .i_setpt_lock(misc[8]),
    .i_set_active(misc[9]), .i_ready(misc[10]), .i_error(misc[11]), .o_dout(dout), .o_trig_src(tsrc),
    .o_trig_out(tout), .o_spd_thr2(thr2));
  sos_ctrl_model #(.SAMPLE_DIV(4)) u_sos_ctrl_model (.i_clk(clk), .i_rst_b(rst_b), .i_dout(dout), .o_seen(seen));

  always #5 clk = ~clk;

  // ==========================================
  // helpers
  task automatic test_done;
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      test_done;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic chkb(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rv);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, {24'h0, a}, d, x);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, {24'h0, a}, 32'h0, r);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset;
    chkb(hready, 1'b1);
    chk({24'h0, dout}, 32'h0);
    bus(1'b0, 32'h100, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b1, 32'h100, 32'hffffffff, r);
    rd(sos_pkg::OFF_SEL_LO);
    chk(r, 32'h0);
  endtask

  task automatic t_direct;
    logic [4:0] codes [12];
    codes = '{sos_pkg::FN_OVERLOAD, sos_pkg::FN_REMAINING, sos_pkg::FN_HOME_ACT, sos_pkg::FN_HOME_VALID,
      sos_pkg::FN_UNDERVOLT, sos_pkg::FN_STAGE, sos_pkg::FN_BRAKE, sos_pkg::FN_LINEAR, sos_pkg::FN_SETPT_LOCK,
      sos_pkg::FN_SET_ACTIVE, sos_pkg::FN_READY, sos_pkg::FN_ERROR};
    for (int k = 0; k < 12; k++) begin
      wr(sos_pkg::OFF_SEL_LO, {11'h0, sos_pkg::FN_OFF, 3'h0, sos_pkg::FN_ON, 3'h0, codes[k]});
      misc <= 12'h1 << k;
      cyc(8);
      chk({29'h0, seen[2:0]}, 32'h3);
      misc <= ~(12'h1 << k);
      cyc(8);
      chk({29'h0, seen[2:0]}, 32'h2);
    end
  endtask

  task automatic t_torque;
    logic [15:0] cur [4];
    cur = '{16'd110, 16'd111, 16'd90, 16'd89};
    wr(sos_pkg::OFF_TRQ_TC, 32'h0);
    wr(sos_pkg::OFF_TRQ_CMP, 32'd100);
    wr(sos_pkg::OFF_TRQ_WIN, 32'd10);
    for (int k = 0; k < 4; k++) begin
      current <= cur[k];
      cyc(250);
      chkb(dout[4], (k % 2) == 0);
      rd(sos_pkg::OFF_FILT);
      chk({16'h0, r[15:0]}, {16'h0, cur[k]});
    end
    wr(sos_pkg::OFF_TRQ_TC, 32'h4);
    current <= 16'd1189;
    cyc(150);
    rd(sos_pkg::OFF_FILT);
    chkb(r[15:0] > 16'd89 && r[15:0] < 16'd1189, 1'b1);
  endtask

  task automatic t_speed;
    wr(sos_pkg::OFF_SPD_CMP, 32'd1000);
    wr(sos_pkg::OFF_SPD_WIN, 32'd5);
    wr(sos_pkg::OFF_SPD_DLY, 32'd3);
    wr(sos_pkg::OFF_SPD_THR2, 32'd1005);
    speed <= 32'd1005;
    cyc(190);
    chkb(dout[5], 1'b0);
    chkb(thr2, 1'b1);
    speed <= 32'd1006;
    cyc(1);
    speed <= 32'd1005;
    cyc(190);
    chkb(dout[5], 1'b0);
    cyc(310);
    chkb(dout[5], 1'b1);
    speed <= 32'd1006;
    cyc(3);
    chkb(dout[5], 1'b0);
    speed <= 32'd995;
    cyc(500);
    chkb(dout[5], 1'b1);
    chkb(thr2, 1'b0);
  endtask

  task automatic t_target;
    wr(sos_pkg::OFF_TGT_NEG, 32'd10);
    wr(sos_pkg::OFF_TGT_POS, 32'd20);
    wr(sos_pkg::OFF_TGT_DLY, 32'd1);
    pos_tgt <= 32'd0;
    pos_act <= -32'd10;
    cyc(250);
    chkb(dout[6], 1'b1);
    pos_tgt <= -32'd5;
    cyc(3);
    chkb(dout[6], 1'b1);
    pos_act <= 32'd16;
    cyc(3);
    chkb(dout[6], 1'b0);
    pos_act <= 32'd15;
    cyc(250);
    chkb(dout[6], 1'b1);
    pos_act <= -32'd16;
    cyc(3);
    chkb(dout[6], 1'b0);
  endtask

  task automatic t_follow;
    wr(sos_pkg::OFF_FE_NEG, 32'd5);
    wr(sos_pkg::OFF_FE_POS, 32'd7);
    wr(sos_pkg::OFF_FE_DLY, 32'd1);
    pos_set <= 32'd100;
    pos_act <= 32'd107;
    cyc(250);
    chkb(dout[7], 1'b0);
    pos_act <= 32'd108;
    cyc(250);
    chkb(dout[7], 1'b1);
    pos_act <= 32'd95;
    cyc(3);
    chkb(dout[7], 1'b0);
  endtask

  task automatic t_trig;
    wr(sos_pkg::OFF_SEL_LO, {3'h0, sos_pkg::FN_TRIG1, 3'h0, 5'(sos_pkg::FN_TRIG1 + 5'h1), 16'h0});
    pos_act <= 32'd50;
    angle <= 16'h0;
    wr(sos_pkg::OFF_PT_LEFT, 32'd0);
    wr(sos_pkg::OFF_PT_RIGHT, 32'd100);
    wr(sos_pkg::OFF_PT_LEFT + 8'h4, 32'd200);
    wr(sos_pkg::OFF_PT_RIGHT + 8'h4, 32'd300);
    wr(sos_pkg::OFF_RT_LEFT, -32'd100);
    wr(sos_pkg::OFF_RT_RIGHT, 32'd100);
    wr(sos_pkg::OFF_TRIG_CFG, 32'h13);
    wr(sos_pkg::OFF_TRIG_MAP, 32'h0004_1003);
    cyc(5);
    rd(sos_pkg::OFF_TRIG_MAP);
    chk(r, 32'h1003);
    rd(sos_pkg::OFF_STATUS);
    chk({20'h0, r[11:0]}, 32'h311);
    chk({30'h0, dout[3:2]}, 32'h3);
    wr(sos_pkg::OFF_TRIG_MAP, 32'h1013);
    rd(sos_pkg::OFF_TRIG_MAP);
    chk(r, 32'h1003);
    rd(sos_pkg::OFF_STATUS);
    chkb(r[25], 1'b1);
    wr(sos_pkg::OFF_TRIG_CFG, 32'h113);
    cyc(3);
    chk({24'h0, tsrc}, 32'h10);
    pos_act <= 32'd250;
    cyc(3);
    chk({24'h0, tsrc}, 32'h13);
    wr(sos_pkg::OFF_TRIG_CFG, 32'h111);
    rd(sos_pkg::OFF_TRIG_MAP);
    chk(r, 32'h1001);
    angle <= 16'd101;
    cyc(4);
    chk({28'h0, tout}, 32'h1);
    wr(sos_pkg::OFF_TRIG_MAP, 32'h0101_1001);
    wr(sos_pkg::OFF_SEL_LO, {19'h0, 5'(sos_pkg::FN_TRIG1 + 5'h3), 3'h0, 5'(sos_pkg::FN_TRIG1 + 5'h2)});
    cyc(4);
    chk({30'h0, dout[1:0]}, 32'h3);
  endtask

  initial begin
    cyc(20);
    rst_b <= 1'b1;
    t_reset;
    wr(sos_pkg::OFF_SEL_HI, {3'h0, sos_pkg::FN_FOLLOW, 3'h0, sos_pkg::FN_TARGET, 3'h0, sos_pkg::FN_SPEED,
      3'h0, sos_pkg::FN_TORQUE});
    t_direct;
    t_torque;
    t_speed;
    t_target;
    t_follow;
    t_trig;
    test_done;
  end
endmodule
